/* hw/bridge_window_pkg.sv */
// Constants for the bridge bus-number, I/O window and status registers.
package bridge_window_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] OFF_HDR = 8'h0c;
  localparam logic [7:0] OFF_BUS = 8'h18;
  localparam logic [7:0] OFF_IOSTAT = 8'h1c;
  localparam logic [7:0] OFF_IO_UPPER = 8'h30;
  localparam logic [7:0] OFF_CTRL = 8'h3c;
  localparam logic [7:0] LATENCY_VAL = 8'h00;
  localparam logic [7:0] HEADER_TYPE_VAL = 8'h01;
  localparam logic [7:0] BUS_RST = 8'h00;
  localparam logic [3:0] IO_ADDR32_IND = 4'h1;
  localparam logic [3:0] IO_NIB_RST = 4'h0;
  localparam logic [15:0] IO_UPPER_RST = 16'h0000;
  localparam logic [11:0] IO_LOW_ZERO = 12'h000;
  localparam logic [11:0] IO_LOW_ONES = 12'hfff;
  localparam int CTRL_PER_BIT = 0;
  localparam int CTRL_SERR_BIT = 1;
  localparam int NUM_FLAGS = 6;
  localparam int FLAG_MPE = 0;
  localparam int FLAG_STA = 1;
  localparam int FLAG_RTA = 2;
  localparam int FLAG_RMA = 3;
  localparam int FLAG_SSE = 4;
  localparam int FLAG_DPE = 5;
  localparam logic [NUM_FLAGS-1:0] FLAG_W1C_MASK = 6'h31;
  localparam logic [NUM_FLAGS-1:0] FLAG_RST = 6'h00;
  localparam int POS_MPE = 24;
  localparam int POS_STA = 27;
  localparam int POS_RTA = 28;
  localparam int POS_RMA = 29;
  localparam int POS_SSE = 30;
  localparam int POS_DPE = 31;
endpackage

/* hw/bridge_bus_io_window_regs.sv */
// Bridge bus numbers, I/O forwarding window and secondary status registers.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// (R1) Both latency timer bytes read constant zero.
// (R2) Header type byte reads one at 0Ch.
// (R3) Primary bus number, RW, resets zero.
// (R4) Secondary bus number, RW, resets zero.
// (R5) Subordinate bus number, RW, resets zero.
// (R6) I/O base/limit low nibbles read one.
// (R7) Base nibble gives address 15:12, low zeros.
// (R8) Limit nibble gives address 15:12, low ones.
// (R9) Forward I/O only inside base..limit range.
// (R10) Upper 16 bounds come from upper registers.
// (R11) Status bits 21, 23, 26:25 read zero.
// (R12) Parity flag set only when response enabled.
// (R13) Completer abort sent flag, read-only sticky.
// (R14) Completer abort received flag, read-only sticky.
// (R15) Unsupported request received flag, read-only sticky.
// (R16) System error flag needs report enable, W1C.
// (R17) Poisoned TLP flag, write-one-to-clear.
// (R18) Write one clears; new event beats clear.
// (R19) Reserved status bits read zero, ignore writes.
module bridge_bus_io_window_regs
  import bridge_window_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [DATA_W-1:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [DATA_W-1:0] readdata,
  output logic waitrequest,
  input wire logic sec_parity_err,
  input wire logic sec_abort_sent,
  input wire logic sec_abort_rcvd,
  input wire logic sec_unsupp_rcvd,
  input wire logic err_msg_sent,
  input wire logic sec_poisoned_rcvd,
  input wire logic io_req_valid,
  input wire logic [31:0] io_req_addr,
  output logic io_forward,
  output logic [7:0] upstream_bus_num,
  output logic [7:0] downstream_bus_num,
  output logic [7:0] highest_bus_num
);

  logic ack_r;
  logic [DATA_W-1:0] rdata_r;
  logic [7:0] up_bus_r;
  logic [7:0] dn_bus_r;
  logic [7:0] hi_bus_r;
  logic [3:0] io_base_nib_r;
  logic [3:0] io_lim_nib_r;
  logic [15:0] io_base_up_r;
  logic [15:0] io_lim_up_r;
  logic [1:0] ctrl_r;
  logic [NUM_FLAGS-1:0] flag_r;
  logic io_fwd_r;

  // One wait state per access: the first cycle registers the read data,
  // the second releases waitrequest so the data is already stable.
  wire req = read | write;
  assign waitrequest = req & ~ack_r;
  wire wr_fire = write & ack_r;
  wire sel_hdr = address == OFF_HDR;
  wire sel_bus = address == OFF_BUS;
  wire sel_iostat = address == OFF_IOSTAT;
  wire sel_upper = address == OFF_IO_UPPER;
  wire sel_ctrl = address == OFF_CTRL;
  wire wr_bus = wr_fire & sel_bus;
  wire wr_iostat = wr_fire & sel_iostat;
  wire wr_upper = wr_fire & sel_upper;
  wire wr_ctrl = wr_fire & sel_ctrl;

  wire per_en = ctrl_r[CTRL_PER_BIT];
  wire serr_en = ctrl_r[CTRL_SERR_BIT];

  // Hardware events feeding the sticky flags.
  wire [NUM_FLAGS-1:0] flag_ev;
  assign flag_ev[FLAG_MPE] = sec_parity_err & per_en; // R12
  assign flag_ev[FLAG_STA] = sec_abort_sent; // R13
  assign flag_ev[FLAG_RTA] = sec_abort_rcvd; // R14
  assign flag_ev[FLAG_RMA] = sec_unsupp_rcvd; // R15
  assign flag_ev[FLAG_SSE] = err_msg_sent & serr_en; // R16
  assign flag_ev[FLAG_DPE] = sec_poisoned_rcvd; // R17

  // Clear requests from a byte-3 write; read-only flags are masked out.
  wire w1c_lane = wr_iostat & byteenable[3];
  wire [NUM_FLAGS-1:0] wr_ones;
  assign wr_ones[FLAG_MPE] = writedata[POS_MPE];
  assign wr_ones[FLAG_STA] = writedata[POS_STA];
  assign wr_ones[FLAG_RTA] = writedata[POS_RTA];
  assign wr_ones[FLAG_RMA] = writedata[POS_RMA];
  assign wr_ones[FLAG_SSE] = writedata[POS_SSE];
  assign wr_ones[FLAG_DPE] = writedata[POS_DPE];
  wire [NUM_FLAGS-1:0] flag_clr =
    {NUM_FLAGS{w1c_lane}} & wr_ones & FLAG_W1C_MASK; // R18

  // Read words; unused fields and reserved bits are constant zero.
  wire [15:0] sec_status = {flag_r[FLAG_DPE], flag_r[FLAG_SSE],
    flag_r[FLAG_RMA], flag_r[FLAG_RTA], flag_r[FLAG_STA], 2'b00,
    flag_r[FLAG_MPE], 8'h00}; // R11 R19
  wire [31:0] word_hdr = {8'h00, HEADER_TYPE_VAL, LATENCY_VAL,
    8'h00}; // R1 R2
  wire [31:0] word_bus = {LATENCY_VAL, hi_bus_r, dn_bus_r,
    up_bus_r}; // R1
  wire [31:0] word_iostat = {sec_status, io_lim_nib_r, IO_ADDR32_IND,
    io_base_nib_r, IO_ADDR32_IND}; // R6
  wire [31:0] word_upper = {io_lim_up_r, io_base_up_r};
  wire [31:0] word_ctrl = {30'h0, ctrl_r};
  wire [31:0] rd_mux = sel_hdr ? word_hdr :
    sel_bus ? word_bus :
    sel_iostat ? word_iostat :
    sel_upper ? word_upper :
    sel_ctrl ? word_ctrl : 32'h0000_0000;
  assign readdata = rdata_r;

  // Full 32-bit window bounds.
  wire [31:0] io_bottom = {io_base_up_r, io_base_nib_r,
    IO_LOW_ZERO}; // R7 R10
  wire [31:0] io_top = {io_lim_up_r, io_lim_nib_r,
    IO_LOW_ONES}; // R8 R10
  wire io_in_range = (io_req_addr >= io_bottom) &&
    (io_req_addr <= io_top);
  assign io_forward = io_fwd_r;
  assign upstream_bus_num = up_bus_r;
  assign downstream_bus_num = dn_bus_r;
  assign highest_bus_num = hi_bus_r;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r <= req & ~ack_r;
      if (read & ~ack_r) begin
        rdata_r <= rd_mux;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      up_bus_r <= BUS_RST;
      dn_bus_r <= BUS_RST;
      hi_bus_r <= BUS_RST;
    end else begin
      if (wr_bus & byteenable[0]) begin
        up_bus_r <= writedata[7:0]; // R3
      end
      if (wr_bus & byteenable[1]) begin
        dn_bus_r <= writedata[15:8]; // R4
      end
      if (wr_bus & byteenable[2]) begin
        hi_bus_r <= writedata[23:16]; // R5
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      io_base_nib_r <= IO_NIB_RST;
      io_lim_nib_r <= IO_NIB_RST;
    end else begin
      if (wr_iostat & byteenable[0]) begin
        io_base_nib_r <= writedata[7:4]; // R7
      end
      if (wr_iostat & byteenable[1]) begin
        io_lim_nib_r <= writedata[15:12]; // R8
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      io_base_up_r <= IO_UPPER_RST;
      io_lim_up_r <= IO_UPPER_RST;
      ctrl_r <= 2'b00;
    end else begin
      if (wr_upper & byteenable[0]) begin
        io_base_up_r[7:0] <= writedata[7:0];
      end
      if (wr_upper & byteenable[1]) begin
        io_base_up_r[15:8] <= writedata[15:8];
      end
      if (wr_upper & byteenable[2]) begin
        io_lim_up_r[7:0] <= writedata[23:16];
      end
      if (wr_upper & byteenable[3]) begin
        io_lim_up_r[15:8] <= writedata[31:24];
      end
      if (wr_ctrl & byteenable[0]) begin
        ctrl_r <= writedata[1:0];
      end
    end
  end

  // A set in the same cycle as a clear wins, so no event is lost.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_FLAGS; gi++) begin : g_flag
      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          flag_r[gi] <= FLAG_RST[gi];
        end else begin
          flag_r[gi] <= flag_ev[gi] | (flag_r[gi] & ~flag_clr[gi]); // R18
        end
      end
    end
  endgenerate

  // The forwarding decision is registered: one cycle after the request.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      io_fwd_r <= 1'b0;
    end else begin
      io_fwd_r <= io_req_valid & io_in_range; // R9
    end
  end

  // Every check runs on the bus clock; a reset aborts any attempt in
  // flight, so a mid-run reset leaves no stale expectation behind.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  // Steps of one bus access.
  sequence s_req_start;
    req && !ack_r;
  endsequence
  sequence s_answer;
    !waitrequest;
  endsequence
  sequence s_read_start;
    read && !ack_r;
  endsequence
  sequence s_write_land;
    write && ack_r;
  endsequence

  // Handshake: one wait state, an idle bus is never stalled, and read
  // data only moves when a new read is taken.
  a_wait_one_state: assert property (
    s_req_start |-> waitrequest ##1 s_answer)
    else $error("Access not answered after one wait state.");
  a_idle_no_wait: assert property (
    !req |-> !waitrequest)
    else $error("Wait state raised with no request pending.");
  a_read_data_hold: assert property (
    !(read && !ack_r) |=> $stable(readdata))
    else $error("Read data changed without a new read.");

  // Constant fields.
  a_hdr_read_const: assert property ( // R1 R2
    (read && sel_hdr && !ack_r) |=> (readdata == 32'h0001_0000))
    else $error("Header word does not read constant value.");
  a_lat_bytes_zero: assert property ( // R1
    (read && sel_bus && !ack_r) |=> (readdata[31:24] == 8'h00))
    else $error("Secondary latency byte not zero.");
  a_io_nibble_one: assert property ( // R6
    (read && sel_iostat && !ack_r) |=>
    (readdata[3:0] == 4'h1 && readdata[11:8] == 4'h1))
    else $error("I/O addressing indicator wrong.");
  a_status_rsvd_zero: assert property ( // R11 R19
    (read && sel_iostat && !ack_r) |=>
    (readdata[23:16] == 8'h00 && readdata[26:25] == 2'b00))
    else $error("Reserved or fixed status bits not zero.");

  // Unmapped words are answered but hold nothing.
  a_unmapped_zero: assert property (
    (s_read_start ##0 !(sel_hdr || sel_bus || sel_iostat || sel_upper ||
    sel_ctrl)) |=> (readdata == 32'h0000_0000))
    else $error("Unmapped word did not read zero.");

  // Bus numbers: each byte lane lands on its own field, and nothing else
  // moves them.
  a_pri_bus_write: assert property ( // R3
    (s_write_land ##0 (sel_bus && byteenable[0])) |=>
    (up_bus_r == $past(writedata[7:0])))
    else $error("Upstream bus number not written.");
  a_bus_num_write: assert property ( // R4
    (wr_bus && byteenable[1]) |=> (dn_bus_r == $past(writedata[15:8])))
    else $error("Secondary bus number not written.");
  a_sub_bus_write: assert property ( // R5
    (s_write_land ##0 (sel_bus && byteenable[2])) |=>
    (hi_bus_r == $past(writedata[23:16])))
    else $error("Highest bus number not written.");
  a_bus_num_hold: assert property ( // R3 R4 R5
    !wr_bus |=> $stable({hi_bus_r, dn_bus_r, up_bus_r}))
    else $error("Bus number changed without a write.");
  a_bus_read_back: assert property ( // R3 R4 R5
    (s_read_start ##0 sel_bus) |=>
    (readdata[23:0] == $past({hi_bus_r, dn_bus_r, up_bus_r})))
    else $error("Bus numbers do not read back.");

  // I/O window: nibbles and upper halves are taken as written, and the
  // miss check compares whole 4K pages, so it does not lean on the bounds.
  a_base_nib_write: assert property ( // R7
    (wr_iostat && byteenable[0]) |=>
    (io_base_nib_r == $past(writedata[7:4])))
    else $error("I/O window bottom nibble not written.");
  a_lim_nib_write: assert property ( // R8
    (wr_iostat && byteenable[1]) |=>
    (io_lim_nib_r == $past(writedata[15:12])))
    else $error("I/O window top nibble not written.");
  a_base_up_write: assert property ( // R10
    (wr_upper && byteenable[1:0] == 2'h3) |=>
    (io_base_up_r == $past(writedata[15:0])))
    else $error("Upper half of window bottom not written.");
  a_lim_up_write: assert property ( // R10
    (wr_upper && byteenable[3:2] == 2'h3) |=>
    (io_lim_up_r == $past(writedata[31:16])))
    else $error("Upper half of window top not written.");
  a_window_hit: assert property ( // R9
    (io_req_valid && io_req_addr >= io_bottom && io_req_addr <= io_top)
    |=> io_forward)
    else $error("In-window I/O request not forwarded.");
  a_window_miss: assert property ( // R7 R8 R9 R10
    (!io_req_valid || io_req_addr[31:12] < {io_base_up_r, io_base_nib_r} ||
    io_req_addr[31:12] > {io_lim_up_r, io_lim_nib_r}) |=> !io_forward)
    else $error("Out-of-window I/O request forwarded.");

  // Enables: the control bits gate the parity and system error flags.
  a_ctrl_write: assert property ( // R12 R16
    (wr_ctrl && byteenable[0]) |=>
    (ctrl_r == $past(writedata[1:0])))
    else $error("Error enable bits not written.");

  // Status flags: each event sets its flag a cycle later, the enables gate
  // the two reported errors, and only write-one-to-clear flags clear.
  a_parity_gated: assert property ( // R12
    (!per_en && !flag_r[FLAG_MPE]) |=> !flag_r[FLAG_MPE])
    else $error("Parity flag set while response disabled.");
  a_parity_set: assert property ( // R12
    (sec_parity_err && per_en) |=> flag_r[FLAG_MPE])
    else $error("Parity flag not set.");
  a_abort_sent_set: assert property ( // R13
    sec_abort_sent |=> flag_r[FLAG_STA])
    else $error("Abort sent flag not set.");
  a_abort_rcvd_set: assert property ( // R14
    sec_abort_rcvd |=> flag_r[FLAG_RTA])
    else $error("Abort received flag not set.");
  a_unsupp_set: assert property ( // R15
    sec_unsupp_rcvd |=> flag_r[FLAG_RMA])
    else $error("Unsupported request flag not set.");
  a_sys_err_gated: assert property ( // R16
    (err_msg_sent && serr_en) |=> flag_r[FLAG_SSE])
    else $error("System error flag not set.");
  a_sys_err_block: assert property ( // R16
    (!serr_en && !flag_r[FLAG_SSE]) |=> !flag_r[FLAG_SSE])
    else $error("System error flag set while reporting disabled.");
  a_poison_set: assert property ( // R17
    sec_poisoned_rcvd |=> flag_r[FLAG_DPE])
    else $error("Poisoned arrival flag not set.");
  a_set_beats_clear: assert property ( // R18
    (sec_poisoned_rcvd && flag_clr[FLAG_DPE]) |=> flag_r[FLAG_DPE])
    else $error("Clear beat a new poisoned event.");
  a_poison_clear: assert property ( // R17 R18
    (flag_clr[FLAG_DPE] && !sec_poisoned_rcvd) |=> !flag_r[FLAG_DPE])
    else $error("Poisoned arrival flag not cleared.");
  a_sys_err_clear: assert property ( // R16 R18
    (flag_clr[FLAG_SSE] && !flag_ev[FLAG_SSE]) |=> !flag_r[FLAG_SSE])
    else $error("System error flag not cleared.");
  a_parity_clear: assert property ( // R12 R18
    (flag_clr[FLAG_MPE] && !flag_ev[FLAG_MPE]) |=> !flag_r[FLAG_MPE])
    else $error("Parity flag not cleared.");
  a_flag_quiet: assert property ( // R18
    (flag_ev == '0 && flag_clr == '0) |=> $stable(flag_r))
    else $error("Status flag moved with no event and no clear.");
  a_ro_flag_sticky: assert property ( // R13
    flag_r[FLAG_STA] |=> flag_r[FLAG_STA] [*2])
    else $error("Read-only abort flag cleared.");
  a_rta_sticky: assert property ( // R14
    flag_r[FLAG_RTA] |=> flag_r[FLAG_RTA])
    else $error("Abort received flag cleared.");
  a_rma_sticky: assert property ( // R15
    flag_r[FLAG_RMA] |=> flag_r[FLAG_RMA])
    else $error("Unsupported request flag cleared.");

endmodule // bridge_bus_io_window_regs
`default_nettype wire

/* testbench/bus_host.sv */
// Host model issuing configuration accesses over the register bus.
`timescale 1ns/10ps
`default_nettype none
module bus_host
  import bridge_window_pkg::*;
(
  input wire logic ref_clk,
  input wire logic waitrequest,
  input wire logic [DATA_W-1:0] readdata,
  output logic [ADDR_W-1:0] address,
  output logic read,
  output logic write,
  output logic [DATA_W-1:0] writedata,
  output logic [3:0] byteenable
);
  initial begin
    address = 8'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    byteenable = 4'h0;
  end

  // One access; the request is held until waitrequest is seen low.
  task automatic xfer(input logic rd, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d,
                      input logic [3:0] be,
                      output logic [DATA_W-1:0] q);
    @(posedge ref_clk);
    address <= a;
    read <= rd;
    write <= ~rd;
    writedata <= d;
    byteenable <= be;
    do @(posedge ref_clk); while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    // Released data is inverted so a stale value cannot pass for a fresh one.
    writedata <= ~d;
    byteenable <= 4'h0;
  endtask
endmodule // bus_host
`default_nettype wire

/* testbench/tb_top.sv */
// Self-checking bench for the bus number, I/O window and status block.
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import bridge_window_pkg::*;
;
  localparam logic [31:0] PROBE [5] = '{32'h0001_2fff, 32'h0001_3000,
    32'h0001_5fff, 32'h0001_6000, 32'h0000_4000};
  localparam logic [4:0] HIT = 5'h06;
  logic ref_clk;
  logic arst_n;
  logic [5:0] ev;
  logic io_req_valid;
  logic [31:0] io_req_addr;
  logic [ADDR_W-1:0] address;
  logic read;
  logic write;
  logic [DATA_W-1:0] writedata;
  logic [3:0] byteenable;
  logic [DATA_W-1:0] readdata;
  logic waitrequest;
  logic io_forward;
  logic [7:0] up_bus;
  logic [7:0] dn_bus;
  logic [7:0] hi_bus;
  logic [DATA_W-1:0] q;
  int failures;
  int check_count;

  bridge_bus_io_window_regs DUT (.ref_clk(ref_clk), .arst_n(arst_n),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .sec_parity_err(ev[FLAG_MPE]),
    .sec_abort_sent(ev[FLAG_STA]), .sec_abort_rcvd(ev[FLAG_RTA]),
    .sec_unsupp_rcvd(ev[FLAG_RMA]), .err_msg_sent(ev[FLAG_SSE]),
    .sec_poisoned_rcvd(ev[FLAG_DPE]), .io_req_valid(io_req_valid),
    .io_req_addr(io_req_addr), .io_forward(io_forward),
    .upstream_bus_num(up_bus), .downstream_bus_num(dn_bus),
    .highest_bus_num(hi_bus));
  bus_host host (.ref_clk(ref_clk), .waitrequest(waitrequest),
    .readdata(readdata), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    host.xfer(1'b1, a, 32'h0, 4'hf, q);
    chk(q, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b0, a, d, 4'hf, q);
  endtask
  task automatic wr_be(input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] be);
    host.xfer(1'b0, a, d, be, q);
  endtask
  task automatic pulse(input logic [5:0] v);
    @(posedge ref_clk);
    ev <= v;
    @(posedge ref_clk);
    ev <= 6'h00;
  endtask

  task automatic t_reset;
    arst_n <= 1'b0;
    repeat (12) @(posedge ref_clk);
    arst_n <= 1'b1;
    chk({30'h0, waitrequest, io_forward}, 32'h0);
    rd(OFF_HDR, 32'h0001_0000);
    rd(OFF_BUS, 32'h0000_0000);
    rd(OFF_IOSTAT, 32'h0000_0101);
    chk({8'h00, hi_bus, dn_bus, up_bus}, 32'h0);
  endtask
  task automatic t_regs;
    wr(OFF_BUS, 32'hff33_2211);
    rd(OFF_BUS, 32'h0033_2211);
    chk({8'h00, hi_bus, dn_bus, up_bus}, 32'h0033_2211);
    // Only the enabled lane may move.
    wr_be(OFF_BUS, 32'h0077_6655, 4'h2);
    rd(OFF_BUS, 32'h0033_6611);
    chk({8'h00, hi_bus, dn_bus, up_bus}, 32'h0033_6611);
    wr(OFF_HDR, 32'hffff_ffff);
    rd(OFF_HDR, 32'h0001_0000);
    wr(OFF_IOSTAT, 32'h00ff_a5f0);
    rd(OFF_IOSTAT, 32'h0000_a1f1);
    // An unmapped word is still answered but holds nothing.
    wr(8'h40, 32'hffff_ffff);
    rd(8'h40, 32'h0000_0000);
  endtask
  task automatic t_window;
    wr(OFF_IO_UPPER, 32'h0001_0001);
    wr(OFF_IOSTAT, 32'h0000_5030);
    for (int i = 0; i < 5; i++) begin
      @(posedge ref_clk);
      io_req_valid <= 1'b1;
      io_req_addr <= PROBE[i];
      @(posedge ref_clk);
      #1;
      chk({31'h0, io_forward}, {31'h0, HIT[i]});
    end
    @(posedge ref_clk);
    io_req_valid <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk({31'h0, io_forward}, 32'h0);
  endtask
  task automatic t_flags;
    wr(OFF_CTRL, 32'h0);
    pulse(6'h3f);
    rd(OFF_IOSTAT, 32'hb800_5131);
    // Ones in the status byte clear nothing unless its lane is enabled.
    wr_be(OFF_IOSTAT, 32'hff00_5030, 4'h7);
    rd(OFF_IOSTAT, 32'hb800_5131);
    wr(OFF_CTRL, 32'h3);
    pulse(6'h3f);
    rd(OFF_IOSTAT, 32'hf900_5131);
    wr(OFF_IOSTAT, 32'hffff_5030);
    rd(OFF_IOSTAT, 32'h3800_5131);
    // A poisoned arrival on the clearing edge must survive the clear.
    fork
      wr(OFF_IOSTAT, 32'h8000_5030);
      begin
        repeat (2) @(posedge ref_clk);
        ev <= 6'h20;
        @(posedge ref_clk);
        ev <= 6'h00;
      end
    join
    rd(OFF_IOSTAT, 32'hb800_5131);
  endtask

  task automatic wrap_up;
    if (failures == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (4000) @(posedge ref_clk);
    failures++;
    wrap_up;
  end

  initial begin
    arst_n = 1'b0;
    ev = 6'h00;
    io_req_valid = 1'b0;
    io_req_addr = 32'h0;
    failures = 0;
    check_count = 0;
    t_reset;
    t_regs;
    t_window;
    t_flags;
    t_reset;
    wrap_up;
  end
endmodule // tb_top
`default_nettype wire
